//--- ceie_cfg.svh
`ifndef CEIE_CFG_SVH
`define CEIE_CFG_SVH

// ==========================================================
// Register addresses in the SFR space
`define CEIE_ADDR_TEC 8'h9c
`define CEIE_ADDR_REC 8'h9d
`define CEIE_ADDR_IE 8'hc1
`define CEIE_ADDR_AVAIL_HI 8'hce
`define CEIE_ADDR_AVAIL_LO 8'hcf

// ==========================================================
// Reset values
`define CEIE_CNT_RST 8'h00
`define CEIE_IE_RST 5'h00
`define CEIE_RDATA_RST 8'h00
`define CEIE_OBJ_RST 15'h0000

// ==========================================================
// Field positions
`define CEIE_IE_MSB 5
`define CEIE_IE_LSB 1
`define CEIE_HI_MSB 6
`define CEIE_OBJ_HI_LSB 8
`define CEIE_OBJ_TOP 14
`define CEIE_NUM_OBJ 15

// ==========================================================
// Fault confinement figures
`define CEIE_STEP_BIG 8'h08
`define CEIE_STEP_ONE 8'h01
`define CEIE_CNT_MAX 8'hff
`define CEIE_PASSIVE_LIMIT 8'h7f
`define CEIE_REC_CLAMP 8'h7f

`endif

//--- ceie_pkg.sv
// ==========================================================
// Shared types for the error counter and enable slice
package ceie_pkg;

  // One SFR byte
  typedef logic [7:0] ceie_byte_t;

  // Register selected by the SFR address decode
  typedef enum {
    CEIE_SEL_NONE,
    CEIE_SEL_TEC,
    CEIE_SEL_REC,
    CEIE_SEL_IE,
    CEIE_SEL_AVAIL_HI,
    CEIE_SEL_AVAIL_LO
  } ceie_sel_t;

endpackage

//--- ceie_fault_cnt.sv
`timescale 1ns/1ps
`include "ceie_cfg.svh"

// ==========================================================
// Saturating fault counter, shared by transmit and receive
module ceie_fault_cnt (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Count events, one-cycle pulses
  input wire logic clear,
  input wire logic inc_big,
  input wire logic inc_one,
  input wire logic dec_one,
  // Clamp on success when above the passive limit
  input wire logic clamp_en,
  // Count and saturation pulse
  output ceie_pkg::ceie_byte_t count,
  output logic overflow
);

  ceie_pkg::ceie_byte_t count_ff; // Counter value
  ceie_pkg::ceie_byte_t nxt_count_ff;
  logic ovf_ff; // Saturation seen last cycle
  logic nxt_ovf_ff;

  // Next count: clear, then increments, then decrement
  always_comb begin
    nxt_count_ff = count_ff;
    nxt_ovf_ff = 1'b0;
    if (clear) begin
      nxt_count_ff = `CEIE_CNT_RST;
    end else if (inc_big) begin
      // Hold at the top rather than wrap
      if (count_ff > 8'(`CEIE_CNT_MAX - `CEIE_STEP_BIG)) begin
        nxt_count_ff = `CEIE_CNT_MAX;
        nxt_ovf_ff = 1'b1;
      end else begin
        nxt_count_ff = 8'(count_ff + `CEIE_STEP_BIG);
      end
    end else if (inc_one) begin
      if (count_ff == `CEIE_CNT_MAX) begin
        nxt_ovf_ff = 1'b1;
      end else begin
        nxt_count_ff = 8'(count_ff + `CEIE_STEP_ONE);
      end
    end else if (dec_one) begin
      // Receive side drops back to the clamp value
      if (clamp_en && (count_ff > `CEIE_PASSIVE_LIMIT)) begin
        nxt_count_ff = `CEIE_REC_CLAMP;
      end else if (count_ff != `CEIE_CNT_RST) begin
        nxt_count_ff = 8'(count_ff - `CEIE_STEP_ONE);
      end
    end
  end

  // Counter registers, cleared at reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_ff <= `CEIE_CNT_RST;
      ovf_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count_ff;
      ovf_ff <= nxt_ovf_ff;
    end
  end

  assign count = count_ff;
  assign overflow = ovf_ff;

  // Saturation never wraps to a small value
  cnt_no_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
    (inc_big && !clear && count_ff == `CEIE_CNT_MAX) |=> (count_ff == `CEIE_CNT_MAX) && ovf_ff)
    else $error("fault counter wrapped");

  // Idle counter holds its value
  cnt_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !(clear || inc_big || inc_one || dec_one) |=> $stable(count_ff))
    else $error("fault counter moved without an event");

endmodule // ceie_fault_cnt

//--- ceie_regs.sv
`timescale 1ns/1ps
`include "ceie_cfg.svh"

// ==========================================================
// Overview of operation
// - Transmit error counter, read-only, resets to zero
// - Separate receive error counter, read-only, resets zero
// - Five enable bits 5..1, cleared at reset
// - High availability bits show objects 14..8 busy
// - Flags clear on done/abort/standby, load the enable bit on rewrite
module ceie_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // SFR access port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output ceie_pkg::ceie_byte_t sfr_rdata,
  // Fault events from the frame engine, one-cycle pulses
  input wire logic tx_error,
  input wire logic tx_success,
  input wire logic rx_error,
  input wire logic rx_error_dominant,
  input wire logic rx_success,
  input wire logic bus_off_recover,
  // Per object events, one-cycle pulses
  input wire logic [14:0] obj_tx_complete,
  input wire logic [14:0] obj_rx_complete,
  input wire logic [14:0] obj_abort,
  input wire logic [14:0] obj_standby,
  input wire logic [14:0] obj_cfg_write,
  input wire logic obj_cfg_enable,
  // Interrupt enables
  output logic rx_done_irq_enable,
  output logic tx_done_irq_enable,
  output logic object_error_irq_enable,
  output logic buffer_full_irq_enable,
  output logic general_error_irq_enable,
  // Object and counter state
  output logic [14:0] object_busy_flag,
  output ceie_pkg::ceie_byte_t transmit_fault_count,
  output ceie_pkg::ceie_byte_t inbound_fault_count,
  output logic error_passive,
  output logic tx_count_overflow
);

  // ==========================================================
  // Declarations
  ceie_pkg::ceie_sel_t sel; // Decoded register
  logic [4:0] irq_en_ff; // Enable bits 5..1
  logic [4:0] nxt_irq_en_ff;
  ceie_pkg::ceie_byte_t rdata_ff; // Registered read data
  ceie_pkg::ceie_byte_t nxt_rdata_ff;
  logic [14:0] busy_ff; // Object availability flags
  logic [14:0] nxt_busy_ff;

  // ==========================================================
  // Address decode
  always_comb begin
    unique case (sfr_addr)
      `CEIE_ADDR_TEC: sel = ceie_pkg::CEIE_SEL_TEC;
      `CEIE_ADDR_REC: sel = ceie_pkg::CEIE_SEL_REC;
      `CEIE_ADDR_IE: sel = ceie_pkg::CEIE_SEL_IE;
      `CEIE_ADDR_AVAIL_HI: sel = ceie_pkg::CEIE_SEL_AVAIL_HI;
      `CEIE_ADDR_AVAIL_LO: sel = ceie_pkg::CEIE_SEL_AVAIL_LO;
      // Any other address is not ours
      default: sel = ceie_pkg::CEIE_SEL_NONE;
    endcase
  end

  // ==========================================================
  // Error counters
  // Transmit side: error adds eight, success subtracts one
  ceie_fault_cnt u_tx_cnt (
    .core_clk(core_clk),
    .reset(reset),
    .clear(bus_off_recover),
    .inc_big(tx_error),
    .inc_one(1'b0),
    .dec_one(tx_success),
    .clamp_en(1'b0),
    .count(transmit_fault_count),
    .overflow(tx_count_overflow)
  );

  // Receive side: error adds one, dominant-bit error adds eight, success clamps above the limit
  ceie_fault_cnt u_rx_cnt (
    .core_clk(core_clk),
    .reset(reset),
    .clear(bus_off_recover),
    .inc_big(rx_error_dominant),
    .inc_one(rx_error),
    .dec_one(rx_success),
    .clamp_en(1'b1),
    .count(inbound_fault_count),
    .overflow()
  );

  // Either counter past the limit means error passive
  assign error_passive = (transmit_fault_count > `CEIE_PASSIVE_LIMIT) ||
                         (inbound_fault_count > `CEIE_PASSIVE_LIMIT);

  // ==========================================================
  // Interrupt enable register
  // Only bits 5..1 are stored; writes to counters are dropped
  always_comb begin
    nxt_irq_en_ff = irq_en_ff;
    if (sfr_wr && (sel == ceie_pkg::CEIE_SEL_IE)) begin
      nxt_irq_en_ff = sfr_wdata[`CEIE_IE_MSB:`CEIE_IE_LSB];
    end
  end

  // Enable storage
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_en_ff <= `CEIE_IE_RST;
    end else begin
      irq_en_ff <= nxt_irq_en_ff;
    end
  end

  // Enable outputs, bit 5 down to bit 1
  assign rx_done_irq_enable = irq_en_ff[4];
  assign tx_done_irq_enable = irq_en_ff[3];
  assign object_error_irq_enable = irq_en_ff[2];
  assign buffer_full_irq_enable = irq_en_ff[1];
  assign general_error_irq_enable = irq_en_ff[0];

  // ==========================================================
  // Object availability flags, one per message object
  generate
    for (genvar i = 0; i < `CEIE_NUM_OBJ; i++) begin : g_obj
      // Rewrite of the control register wins over a same-cycle clear
      always_comb begin
        nxt_busy_ff[i] = busy_ff[i];
        if (obj_cfg_write[i]) begin
          nxt_busy_ff[i] = obj_cfg_enable;
        end else if (obj_tx_complete[i] || obj_rx_complete[i] ||
                     obj_abort[i] || obj_standby[i]) begin
          nxt_busy_ff[i] = 1'b0;
        end
      end
    end
  endgenerate

  // Flag storage, all objects free at reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy_ff <= `CEIE_OBJ_RST;
    end else begin
      busy_ff <= nxt_busy_ff;
    end
  end

  assign object_busy_flag = busy_ff;

  // ==========================================================
  // Read data path
  // Reserved and unmapped bits read as zero; data holds between reads
  always_comb begin
    nxt_rdata_ff = rdata_ff;
    if (sfr_rd) begin
      unique case (sel)
        ceie_pkg::CEIE_SEL_TEC: nxt_rdata_ff = transmit_fault_count;
        ceie_pkg::CEIE_SEL_REC: nxt_rdata_ff = inbound_fault_count;
        ceie_pkg::CEIE_SEL_IE: nxt_rdata_ff = {2'b00, irq_en_ff, 1'b0};
        ceie_pkg::CEIE_SEL_AVAIL_HI:
          nxt_rdata_ff = {1'b0, busy_ff[`CEIE_OBJ_TOP:`CEIE_OBJ_HI_LSB]};
        ceie_pkg::CEIE_SEL_AVAIL_LO:
          nxt_rdata_ff = busy_ff[`CEIE_OBJ_HI_LSB-1:0];
        ceie_pkg::CEIE_SEL_NONE: nxt_rdata_ff = `CEIE_RDATA_RST;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= `CEIE_RDATA_RST;
    end else begin
      rdata_ff <= nxt_rdata_ff;
    end
  end

  assign sfr_rdata = rdata_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Steps of an enable write followed by its read back
  sequence s_ie_write;
    sfr_wr && (sel == ceie_pkg::CEIE_SEL_IE);
  endsequence

  sequence s_ie_read;
    sfr_rd && !sfr_wr && (sel == ceie_pkg::CEIE_SEL_IE);
  endsequence

  sequence s_tx_quiet;
    !bus_off_recover && !tx_error && !tx_success;
  endsequence

  tec_step_a: assert property (
    (tx_error && !bus_off_recover &&
     (transmit_fault_count <= 8'(`CEIE_CNT_MAX - `CEIE_STEP_BIG)))
    |=> transmit_fault_count == 8'($past(transmit_fault_count) + `CEIE_STEP_BIG))
    else $error("transmit counter did not add eight");

  tec_dec_a: assert property (
    (tx_success && !tx_error && !bus_off_recover &&
     (transmit_fault_count != `CEIE_CNT_RST))
    |=> transmit_fault_count == 8'($past(transmit_fault_count) - `CEIE_STEP_ONE))
    else $error("transmit counter did not subtract one");

  tec_ro_a: assert property (
    (sfr_wr && (sel == ceie_pkg::CEIE_SEL_TEC)) ##0 s_tx_quiet
    |=> $stable(transmit_fault_count))
    else $error("transmit counter changed by a write");

  rec_inc_a: assert property (
    (rx_error && !rx_error_dominant && !bus_off_recover &&
     (inbound_fault_count != `CEIE_CNT_MAX))
    |=> inbound_fault_count == 8'($past(inbound_fault_count) + `CEIE_STEP_ONE))
    else $error("receive counter did not add one");

  rec_clamp_a: assert property (
    (rx_success && !rx_error && !rx_error_dominant && !bus_off_recover &&
     (inbound_fault_count > `CEIE_PASSIVE_LIMIT))
    |=> inbound_fault_count == `CEIE_REC_CLAMP)
    else $error("receive counter not clamped");

  cnt_recover_a: assert property (
    bus_off_recover |=> (transmit_fault_count == `CEIE_CNT_RST) &&
                        (inbound_fault_count == `CEIE_CNT_RST))
    else $error("counters not cleared on recovery");

  ie_roundtrip_a: assert property (
    s_ie_write ##1 s_ie_read
    |=> sfr_rdata == {2'b00, $past(sfr_wdata[`CEIE_IE_MSB:`CEIE_IE_LSB], 2), 1'b0})
    else $error("enable read back differs from write");

  ie_hold_a: assert property (
    !(sfr_wr && (sel == ceie_pkg::CEIE_SEL_IE)) [*3]
    |-> $stable(rx_done_irq_enable) && $stable(general_error_irq_enable))
    else $error("enable bits moved without a write");

  busy_clear_a: assert property (
    (!obj_cfg_write[3] && (obj_tx_complete[3] || obj_rx_complete[3] ||
     obj_abort[3] || obj_standby[3]))
    |=> !object_busy_flag[3])
    else $error("object flag not cleared");

  busy_set_a: assert property (
    (obj_cfg_write[3] && obj_cfg_enable) |=> object_busy_flag[3])
    else $error("object flag not set on rewrite");

  hi_read_a: assert property (
    (sfr_rd && (sel == ceie_pkg::CEIE_SEL_AVAIL_HI))
    |=> (sfr_rdata[7] == 1'b0) &&
        (sfr_rdata[`CEIE_HI_MSB:0] == $past(object_busy_flag[`CEIE_OBJ_TOP:`CEIE_OBJ_HI_LSB])))
    else $error("high availability read wrong");

endmodule // ceie_regs

//--- ceie_node_model.sv
`timescale 1ns/1ps

// ==========================================================
// Remote node model: one event code becomes one fault pulse
module ceie_node_model (
  // Event request from the bench
  input wire logic [2:0] ev_code,
  input wire logic ev_go,
  // Fault pulses toward the counters
  output logic tx_error,
  output logic tx_success,
  output logic rx_error,
  output logic rx_error_dominant,
  output logic rx_success,
  output logic bus_off_recover
);
  // Decode a code into a pulse, one kind per cycle
  always_comb begin
    tx_error = ev_go && (ev_code == 3'h1);
    tx_success = ev_go && (ev_code == 3'h2);
    rx_error = ev_go && (ev_code == 3'h3);
    rx_error_dominant = ev_go && (ev_code == 3'h4);
    rx_success = ev_go && (ev_code == 3'h5);
    bus_off_recover = ev_go && (ev_code == 3'h6);
  end
endmodule // ceie_node_model

//--- ceie_regs_tb_top.sv
`timescale 1ns/1ps

// ==========================================================
// Bench for the error counter and enable slice
module ceie_regs_tb_top;
  // Clock, reset and SFR port
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  ceie_pkg::ceie_byte_t sfr_rdata;
  // Event requests and fault pulses
  logic [2:0] ev_code = 3'h0;
  logic ev_go = 1'b0;
  logic txe, txs, rxe, rxd, rxs, rcv;
  // Object event pulses
  logic [14:0] o_cfg = 15'h0000;
  logic [14:0] o_txc = 15'h0000;
  logic [14:0] o_rxc = 15'h0000;
  logic [14:0] o_abt = 15'h0000;
  logic [14:0] o_stb = 15'h0000;
  logic o_en = 1'b0;
  // Design outputs
  logic [4:0] ien;
  logic [14:0] busy;
  ceie_pkg::ceie_byte_t tec, rec;
  logic e_pas, t_ovf;
  // Bookkeeping
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  ceie_pkg::ceie_byte_t rd_val;

  // Free-running 250 MHz clock
  always #2 core_clk = ~core_clk;

  ceie_node_model node (.ev_code(ev_code), .ev_go(ev_go), .tx_error(txe),
    .tx_success(txs), .rx_error(rxe), .rx_error_dominant(rxd),
    .rx_success(rxs), .bus_off_recover(rcv));

  ceie_regs uut (.core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .tx_error(txe), .tx_success(txs),
    .rx_error(rxe), .rx_error_dominant(rxd), .rx_success(rxs),
    .bus_off_recover(rcv), .obj_tx_complete(o_txc), .obj_rx_complete(o_rxc),
    .obj_abort(o_abt), .obj_standby(o_stb), .obj_cfg_write(o_cfg),
    .obj_cfg_enable(o_en), .rx_done_irq_enable(ien[4]),
    .tx_done_irq_enable(ien[3]), .object_error_irq_enable(ien[2]),
    .buffer_full_irq_enable(ien[1]), .general_error_irq_enable(ien[0]),
    .object_busy_flag(busy), .transmit_fault_count(tec),
    .inbound_fault_count(rec), .error_passive(e_pas),
    .tx_count_overflow(t_ovf));

  // Compare and count
  task automatic chk(input string what, input logic [14:0] seen,
    input logic [14:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One SFR write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask

  // One SFR read strobe, data settled one cycle on
  task automatic rchk(input string what, input logic [7:0] a,
    input logic [7:0] exp);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    rd_val = sfr_rdata;
    chk(what, {7'h00, rd_val}, {7'h00, exp});
  endtask

  // Back-to-back fault events of one kind
  task automatic ev(input logic [2:0] c, input int n);
    repeat (n) begin
      @(negedge core_clk);
      ev_code = c;
      ev_go = 1'b1;
    end
    @(negedge core_clk);
    ev_go = 1'b0;
  endtask

  // One object event: 0 rewrite, 1 tx, 2 rx, 3 abort, 4 standby
  task automatic obj(input int k, input int i, input logic en);
    @(negedge core_clk);
    o_en = en;
    case (k)
      0: o_cfg[i] = 1'b1;
      1: o_txc[i] = 1'b1;
      2: o_rxc[i] = 1'b1;
      3: o_abt[i] = 1'b1;
      default: o_stb[i] = 1'b1;
    endcase
    @(negedge core_clk);
    o_cfg = 15'h0000;
    o_txc = 15'h0000;
    o_rxc = 15'h0000;
    o_abt = 15'h0000;
    o_stb = 15'h0000;
  endtask

  // Counts, verdict and end of run
  task automatic final_report();
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    // Reset values and an unmapped read
    rchk("tec", 8'h9c, 8'h00);
    rchk("rec", 8'h9d, 8'h00);
    rchk("ie", 8'hc1, 8'h00);
    rchk("hi", 8'hce, 8'h00);
    rchk("lo", 8'hcf, 8'h00);
    rchk("none", 8'h00, 8'h00);
    // Writes to read-only places have no effect
    wr(8'h9c, 8'h55);
    wr(8'h9d, 8'haa);
    wr(8'hce, 8'h7f);
    wr(8'hcf, 8'hff);
    rchk("tec_ro", 8'h9c, 8'h00);
    rchk("rec_ro", 8'h9d, 8'h00);
    rchk("hi_ro", 8'hce, 8'h00);
    rchk("lo_ro", 8'hcf, 8'h00);
    // Enable bits 5..1 written and read back
    wr(8'hc1, 8'h3e);
    rchk("ie_all", 8'hc1, 8'h3e);
    chk("ien_all", ien, 5'h1f);
    wr(8'hc1, 8'h14);
    rchk("ie_part", 8'hc1, 8'h14);
    chk("ien_part", ien, 5'h0a);
    // Enable write with the read back in the very next cycle
    @(negedge core_clk);
    sfr_addr = 8'hc1;
    sfr_wdata = 8'h2a;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    chk("ie_b2b", {7'h00, sfr_rdata}, 15'h002a);
    chk("ien_b2b", ien, 5'h15);
    // Fault confinement steps
    ev(3'h1, 1);
    rchk("tec_up", 8'h9c, 8'h08);
    ev(3'h2, 1);
    rchk("tec_dn", 8'h9c, 8'h07);
    ev(3'h4, 1);
    ev(3'h3, 1);
    rchk("rec_up", 8'h9d, 8'h09);
    ev(3'h5, 1);
    ev(3'h4, 16);
    chk("rec_big", rec, 8'h88);
    chk("passive", e_pas, 1'b1);
    ev(3'h5, 1);
    rchk("rec_clamp", 8'h9d, 8'h7f);
    ev(3'h1, 32);
    chk("tec_ovf", t_ovf, 1'b1);
    rchk("tec_sat", 8'h9c, 8'hff);
    chk("tec_ovf_end", t_ovf, 1'b0);
    ev(3'h6, 1);
    chk("tec_clr", tec, 8'h00);
    chk("rec_clr", rec, 8'h00);
    chk("active", e_pas, 1'b0);
    // Object flags set on rewrite
    obj(0, 2, 1'b1);
    rchk("lo_set", 8'hcf, 8'h04);
    obj(0, 14, 1'b1);
    rchk("hi_set", 8'hce, 8'h40);
    // Each hardware clear kind
    for (int k = 1; k < 5; k++) begin
      obj(0, 3, 1'b1);
      chk("busy_set", busy, 15'h400c);
      obj(k, 3, 1'b1);
      chk("busy_clr", busy, 15'h4004);
    end
    obj(0, 14, 1'b0);
    rchk("hi_off", 8'hce, 8'h00);
    obj(2, 2, 1'b1);
    rchk("lo_clr", 8'hcf, 8'h00);
    // Reset in mid-run clears counters, enables and flags
    ev(3'h1, 1);
    obj(0, 5, 1'b1);
    chk("busy_pre", busy, 15'h0020);
    @(negedge core_clk);
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    chk("tec_rst", tec, 8'h00);
    chk("rec_rst", rec, 8'h00);
    chk("ien_rst", ien, 5'h00);
    chk("busy_rst", busy, 15'h0000);
    chk("rdata_rst", sfr_rdata, 8'h00);
    rchk("ie_rst", 8'hc1, 8'h00);
    rchk("tec_rst_rd", 8'h9c, 8'h00);
    final_report();
  end
endmodule // ceie_regs_tb_top
